// >>> logic/fwdg_consts.vh
// Purpose: constants of the free watchdog reload/window block
// Assumes: byte addresses on a 32-bit classic wishbone slave
// Notes: included by all design files of the block
`ifndef FWDG_CONSTS_VH
`define FWDG_CONSTS_VH

// register byte offsets
`define FWDG_OFS_KEY 8'h00
`define FWDG_OFS_PSC 8'h04
`define FWDG_OFS_RLD 8'h08
`define FWDG_OFS_STAT 8'h0C
`define FWDG_OFS_WND 8'h10
`define FWDG_OFS_HOLD 8'h14
`define FWDG_OFS_CNT 8'h18

// command keys
`define FWDG_KEY_UNLOCK 16'h5555
`define FWDG_KEY_RELOAD 16'hAAAA
`define FWDG_KEY_START 16'hCCCC

// reset values
`define FWDG_RST_RLD 12'hFFF
`define FWDG_RST_WND 12'hFFF
`define FWDG_RST_PSC 3'h0
`define FWDG_RST_CNT 12'hFFF

// status bit positions
`define FWDG_STAT_PSC_BIT 0
`define FWDG_STAT_RLD_BIT 1
`define FWDG_STAT_WND_BIT 2

// timing: low-speed oscillator period versus bus clock period
`define FWDG_OSC_PERIOD_NS 25000
`define FWDG_CLK_PERIOD_NS 8
`define FWDG_OSC_DIV_CYCLES (`FWDG_OSC_PERIOD_NS / `FWDG_CLK_PERIOD_NS)
`define FWDG_SYNC_TICKS 2

`endif

// >>> logic/fwdg_osc_div.v
// Purpose: one-cycle enable at the low-speed oscillator rate
// Assumes: single clock clk_i, synchronous active-high reset
// Notes: stands in for the free oscillator; one tick every DIV cycles
`include "fwdg_consts.vh"
module fwdg_osc_div #(
   parameter DIV = `FWDG_OSC_DIV_CYCLES
)(
   input wire clk_i,
   input wire rst_i,
   output reg tick_o
);
   localparam CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam [31:0] LAST_FULL = DIV - 1;
   localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];
   reg [CW-1:0] cnt_reg;

   // free-running divider, never stopped by the bus side
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= {CW{1'b0}};
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_reg == LAST);
         if (cnt_reg == LAST)
            cnt_reg <= {CW{1'b0}};
         else
            cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule // fwdg_osc_div

// >>> logic/fwdg_top.v
// Purpose: free watchdog with reload, window and update-status registers
// Assumes: classic wishbone slave, 32-bit data, byte addressing
// Notes: oscillator domain is emulated by an enable from a divider
//        pending writes read back the old value until taken over
//        a reload above the window while running is a fault, not a refresh
//        a run ends on the tick that would take the count to zero
//
// Functional notes
// - 12-bit reload value in low bits, resets to all ones, rest reserved
// - reload key reloads the down-counter from the reload value
// - reload value writes ignored unless unlock key written first
// - reload-update flag (status bit 1) high while reload write pending
// - prescaler-update flag (status bit 0) high while prescaler write pending
// - window-update flag (status bit 2) high while window write pending
// - status register read-only, resets zero, bits 31:3 read zero
// - 12-bit window value, resets to all ones, upper reload limit
// - reload while running counter above window forces a watchdog reset
// - window writes ignored unless unlock key written first
// - registers accept 16-bit and 32-bit accesses
// - start key starts counter; reaching zero generates a reset
// - any other key value re-locks prescaler, reload and window
// - prescaler divides oscillator by 4 to 256 feeding 12-bit counter
// - debug hold bit stops counter while core halted in debug
`include "fwdg_consts.vh"
module fwdg_top #(
   parameter OSC_DIV = `FWDG_OSC_DIV_CYCLES,
   parameter SYNC_TICKS = `FWDG_SYNC_TICKS
)(
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire debug_halt_i,
   output reg wdt_reset_o,
   output reg wdt_running_o
);
   wire osc_tick;
   wire psc_busy;
   wire rld_busy;
   wire wnd_busy;
   wire [2:0] psc_code;
   wire [11:0] reload_value;
   wire [11:0] window_value;
   wire bus_req;
   wire bus_wr;
   wire key_wr;
   wire [15:0] key_val;
   wire psc_wr;
   wire rld_wr;
   wire wnd_wr;
   wire cnt_tick;
   wire frozen;
   wire key_unlock;
   wire key_reload;
   wire key_start;
   wire early_reload;
   wire cnt_expire;
   reg unlock_reg;
   reg debug_hold_bit;
   reg [7:0] psc_cnt_reg;
   reg [11:0] cnt_reg;
   reg [31:0] rdata_next;

   // register offsets as sized constants, so that word indices can be
   // cut from them without widening the case items of the read mux
   localparam [7:0] OFS_PSC = `FWDG_OFS_PSC;
   localparam [7:0] OFS_RLD = `FWDG_OFS_RLD;
   localparam [7:0] OFS_STAT = `FWDG_OFS_STAT;
   localparam [7:0] OFS_WND = `FWDG_OFS_WND;
   localparam [7:0] OFS_HOLD = `FWDG_OFS_HOLD;
   localparam [7:0] OFS_CNT = `FWDG_OFS_CNT;

   // terminal prescaler count for a 3-bit code, 6 and 7 both 1/256
   function [7:0] psc_limit;
      input [2:0] code;
      begin
         case (code)
            3'h0: psc_limit = 8'h03;
            3'h1: psc_limit = 8'h07;
            3'h2: psc_limit = 8'h0F;
            3'h3: psc_limit = 8'h1F;
            3'h4: psc_limit = 8'h3F;
            3'h5: psc_limit = 8'h7F;
            default: psc_limit = 8'hFF;
         endcase
      end
   endfunction

   // address match helper, word aligned
   // a half-word access at offset 2 lands on the same word
   function hit;
      input [7:0] adr;
      input [7:0] ofs;
      begin
         hit = (adr[7:2] == ofs[7:2]);
      end
   endfunction

   // bus decode; half-word or word writes both cover the low lanes
   // writes that miss a low lane are dropped, never merged
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i & (wb_sel_i[1:0] == 2'h3);
   assign key_wr = bus_wr & hit(wb_adr_i, `FWDG_OFS_KEY);
   assign key_val = wb_dat_i[15:0];
   assign psc_wr = bus_wr & unlock_reg & hit(wb_adr_i, `FWDG_OFS_PSC);
   assign rld_wr = bus_wr & unlock_reg & hit(wb_adr_i, `FWDG_OFS_RLD);
   assign wnd_wr = bus_wr & unlock_reg & hit(wb_adr_i, `FWDG_OFS_WND);

   // key decode, shared by the lock and the counter processes
   assign key_unlock = key_wr & (key_val == `FWDG_KEY_UNLOCK);
   assign key_reload = key_wr & (key_val == `FWDG_KEY_RELOAD);
   assign key_start = key_wr & (key_val == `FWDG_KEY_START);

   // oscillator-rate enable
   // its rate sets every crossing delay and the counter step
   fwdg_osc_div #(
      .DIV(OSC_DIV)
   ) u_osc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(osc_tick)
   );

   // prescaler code transfer
   // a write while pending restarts it; the old value stays active
   fwdg_upd_track #(
      .W(3),
      .RST(`FWDG_RST_PSC),
      .SYNC_TICKS(SYNC_TICKS)
   ) u_psc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(psc_wr),
      .wdata_i(wb_dat_i[2:0]),
      .tick_i(osc_tick),
      .busy_o(psc_busy),
      .value_o(psc_code)
   );

   // reload value transfer
   fwdg_upd_track #(
      .W(12),
      .RST(`FWDG_RST_RLD),
      .SYNC_TICKS(SYNC_TICKS)
   ) u_rld (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(rld_wr),
      .wdata_i(wb_dat_i[11:0]),
      .tick_i(osc_tick),
      .busy_o(rld_busy),
      .value_o(reload_value)
   );

   // window value transfer
   fwdg_upd_track #(
      .W(12),
      .RST(`FWDG_RST_WND),
      .SYNC_TICKS(SYNC_TICKS)
   ) u_wnd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wnd_wr),
      .wdata_i(wb_dat_i[11:0]),
      .tick_i(osc_tick),
      .busy_o(wnd_busy),
      .value_o(window_value)
   );

   // write lock: unlock key opens, any other key closes
   // reload and start keys close it too, so unlock before each change
   always @(posedge clk_i)
   begin
      if (rst_i)
         unlock_reg <= 1'b0;
      else if (key_wr)
         unlock_reg <= key_unlock;
   end

   // debug hold control bit, not write protected
   // it belongs to the debug side, not to the watchdog lock
   always @(posedge clk_i)
   begin
      if (rst_i)
         debug_hold_bit <= 1'b0;
      else if (bus_wr && hit(wb_adr_i, `FWDG_OFS_HOLD))
         debug_hold_bit <= wb_dat_i[0];
   end

   // counter stops only when hold is set and the core is halted
   // with the hold bit clear a halted core keeps the count going
   assign frozen = debug_hold_bit & debug_halt_i;
   assign cnt_tick = osc_tick & wdt_running_o & ~frozen &
                     (psc_cnt_reg == psc_limit(psc_code));

   // a refresh above the window is caught here; a stopped counter has
   // no window, so a reload before start only loads the count
   assign early_reload = key_reload & wdt_running_o &
                         (cnt_reg > window_value);
   // the tick that would take the count from 1 to 0 ends the run
   assign cnt_expire = cnt_tick & (cnt_reg <= 12'h001);

   // prescaler stage on oscillator ticks
   always @(posedge clk_i)
   begin
      if (rst_i)
         psc_cnt_reg <= 8'h00;
      else if (!wdt_running_o)
         psc_cnt_reg <= 8'h00; // every start counts a full first step
      else if (osc_tick && !frozen)
      begin
         if (psc_cnt_reg >= psc_limit(psc_code))
            psc_cnt_reg <= 8'h00;
         else
            psc_cnt_reg <= psc_cnt_reg + 8'h01;
      end
   end

   // down-counter, start, reload, window check and timeout
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= `FWDG_RST_CNT;
         wdt_running_o <= 1'b0;
         wdt_reset_o <= 1'b0;
      end
      else
      begin
         wdt_reset_o <= 1'b0;
         if (key_reload)
         begin
            // early reload is a fault, not a refresh
            if (early_reload)
            begin
               wdt_reset_o <= 1'b1;
               wdt_running_o <= 1'b0;
               cnt_reg <= `FWDG_RST_CNT;
            end
            else
               cnt_reg <= reload_value;
         end
         else if (key_start)
            wdt_running_o <= 1'b1;
         else if (cnt_tick)
         begin
            // a pulse also stops the count until the next start key
            if (cnt_expire)
            begin
               wdt_reset_o <= 1'b1;
               wdt_running_o <= 1'b0;
               cnt_reg <= `FWDG_RST_CNT;
            end
            else
               cnt_reg <= cnt_reg - 12'h001;
         end
      end
   end

   // read mux; pending values read back the old active value
   // the update flags tell software that such a value is not yet valid
   always @*
   begin
      rdata_next = 32'h00000000;
      case (wb_adr_i[7:2])
         OFS_PSC[7:2]: rdata_next = {29'h0, psc_code};
         OFS_RLD[7:2]: rdata_next = {20'h0, reload_value};
         OFS_STAT[7:2]:
            rdata_next = {29'h0, wnd_busy, rld_busy, psc_busy};
         OFS_WND[7:2]: rdata_next = {20'h0, window_value};
         OFS_HOLD[7:2]: rdata_next = {31'h0, debug_hold_bit};
         OFS_CNT[7:2]: rdata_next = {20'h0, cnt_reg};
         default: rdata_next = 32'h00000000;
      endcase
   end

   // one-cycle ack; unmapped addresses ack with zero data
   // a held strobe is not taken twice, as ack masks the next request
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rdata_next : 32'h00000000;
      end
   end
endmodule // fwdg_top

// >>> logic/fwdg_upd_track.v
// Purpose: carries one written value over to the counter side
// Assumes: tick_i is the oscillator-rate enable
// Notes: busy_o stays high until SYNC_TICKS ticks have passed
`include "fwdg_consts.vh"
module fwdg_upd_track #(
   parameter W = 12,
   parameter [W-1:0] RST = {W{1'b1}},
   parameter SYNC_TICKS = `FWDG_SYNC_TICKS
)(
   input wire clk_i,
   input wire rst_i,
   input wire wr_i,
   input wire [W-1:0] wdata_i,
   input wire tick_i,
   output reg busy_o,
   output reg [W-1:0] value_o
);
   reg [W-1:0] shadow_reg;
   reg [3:0] cnt_reg;
   localparam [31:0] LAST_FULL = SYNC_TICKS - 1;
   localparam [3:0] LAST = LAST_FULL[3:0];

   // a new write restarts the transfer, so it wins over completion
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         shadow_reg <= RST;
         value_o <= RST;
         busy_o <= 1'b0;
         cnt_reg <= 4'h0;
      end
      else if (wr_i)
      begin
         shadow_reg <= wdata_i;
         busy_o <= 1'b1;
         cnt_reg <= 4'h0;
      end
      else if (busy_o && tick_i)
      begin
         if (cnt_reg == LAST)
         begin
            value_o <= shadow_reg;
            busy_o <= 1'b0;
         end
         else
            cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule // fwdg_upd_track

// >>> tb/fwdg_monitor.sv
// Purpose: bus and reset-output checks on the watchdog top
// Assumes: one clock, synchronous active-high reset
// Notes: sees only top ports; bound below
module fwdg_monitor #(
   parameter OSC_DIV = 8,
   parameter SYNC_TICKS = 2
)(
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire debug_halt_i,
   input wire wdt_reset_o,
   input wire wdt_running_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // request taken, and read answer seen
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire rd = wb_ack_o && !wb_we_i;
   wire start = req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1:0] == 2'h3
      && wb_dat_i[15:0] == 16'hCCCC;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (req |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_start_runs: assert property (start |=> wdt_running_o)
      else $error("start key did not start counter");
   a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset output not a pulse");
   a_reset_if_run: assert property ($rose(wdt_reset_o) |-> $past(wdt_running_o))
      else $error("reset while counter stopped");
   a_reset_stops: assert property (wdt_reset_o |=> !wdt_running_o)
      else $error("counter runs on after reset");
   a_stat_resv: assert property (rd && wb_adr_i == 8'h0C |-> wb_dat_o[31:3] == 0)
      else $error("status reserved bits set");
   a_rld_resv: assert property (rd && wb_adr_i == 8'h08 |-> wb_dat_o[31:12] == 0)
      else $error("reload reserved bits set");
   a_wnd_resv: assert property (rd && wb_adr_i == 8'h10 |-> wb_dat_o[31:12] == 0)
      else $error("window reserved bits set");
   c_start: cover property (start ##1 wdt_running_o);
   c_reset: cover property (wdt_reset_o);
   c_stat: cover property (rd && wb_adr_i == 8'h0C && wb_dat_o[2:0] != 0);
endmodule // fwdg_monitor

bind fwdg_top fwdg_monitor #(.OSC_DIV(OSC_DIV), .SYNC_TICKS(SYNC_TICKS)) mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .debug_halt_i(debug_halt_i), .wdt_reset_o(wdt_reset_o),
   .wdt_running_o(wdt_running_o));

// >>> tb/tb.sv
// Purpose: self-checking bench for the watchdog reload/window block
// Assumes: OSC_DIV 8, SYNC_TICKS 2 keep crossings short
// Notes: random values from an xorshift seeded with 12
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, stb, we, halt;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, v, seed;
   wire [31:0] dat_o;
   wire ack, wdt_rst, run;
   localparam int OSC = 8;
   int num_errors, checks, pulses, p0, n, p;
   fwdg_top #(.OSC_DIV(OSC), .SYNC_TICKS(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .debug_halt_i(halt), .wdt_reset_o(wdt_rst), .wdt_running_o(run));
   initial
   begin
      clk_i = 0;
      forever #4 clk_i = ~clk_i;
   end
   // reset pulses are counted here so none is missed between bus cycles
   always @(posedge clk_i)
      if (wdt_rst === 1'b1) pulses++;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // cycles per counter step for a prescaler code at the bench's rate
   function automatic int psc_period(logic [2:0] c);
      return (c >= 3'h6) ? 256 * OSC : (4 << c) * OSC;
   endfunction
   task automatic print_verdict();
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle; held until ack is sampled high
   task automatic wb(logic w, logic [7:0] a, logic [3:0] s, logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && k < 20)
      begin
         @(posedge clk_i);
         k++;
      end
      rdat = dat_o;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
      if (k == 20)
      begin
         num_errors++;
         print_verdict();
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      wb(1, a, 4'hF, d);
   endtask
   task automatic rd(logic [7:0] a);
      wb(0, a, 4'hF, 32'h0);
   endtask
   // poll status until every pending write has crossed
   task automatic settle();
      int k;
      k = 0;
      rd(8'h0C);
      while (rdat[2:0] !== 3'h0 && k < 30)
      begin
         rd(8'h0C);
         k++;
      end
      chk("stat", rdat, 32'h0);
      if (k == 30) print_verdict();
   endtask
   task automatic wait_pulse();
      n = 0;
      while (pulses == p0 && n < 5000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("pulse", pulses, p0 + 1);
      if (n == 5000) print_verdict();
   endtask
   initial
   begin
      {cyc, stb, we, halt, adr, sel, wdat} = 0;
      seed = 12;
      rst_i = 1;
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      rd(8'h08); chk("rld", rdat, 32'hFFF);
      rd(8'h10); chk("wnd", rdat, 32'hFFF);
      // locked writes and a status write must all be dropped
      wr(8'h08, 32'h123);
      wr(8'h10, 32'h45);
      wr(8'h0C, 32'h7);
      rd(8'h08); chk("rld", rdat, 32'hFFF);
      rd(8'h10); chk("wnd", rdat, 32'hFFF);
      rd(8'h0C); chk("stat", rdat, 32'h0);
      rd(8'h1C); chk("unmapped", rdat, 32'h0);
      repeat (3)
      begin
         v = rnd();
         wr(8'h00, 32'h5555);
         wr(8'h08, v);
         wr(8'h10, v >> 12);
         rd(8'h0C); chk("stat", rdat, 32'h6);
         settle();
         rd(8'h08); chk("rld", rdat, {20'h0, v[11:0]});
         rd(8'h10); chk("wnd", rdat, {20'h0, v[23:12]});
      end
      wr(8'h04, 32'h0);
      rd(8'h0C); chk("stat", rdat, 32'h1);
      settle();
      // half-word lanes act, upper lanes alone do not
      wb(1, 8'h10, 4'h3, 32'hABC);
      settle();
      wb(1, 8'h10, 4'hC, 32'h111);
      rd(8'h10); chk("wnd", rdat, 32'hABC);
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h5);
      rd(8'h10); chk("wnd", rdat, 32'hABC);
      wr(8'h00, 32'h5555);
      wr(8'h08, 32'h2);
      settle();
      wr(8'h00, 32'hAAAA);
      rd(8'h18); chk("cnt", rdat, 32'h2);
      // frozen counter keeps the window case deterministic
      wr(8'h14, 32'h1);
      halt <= 1;
      wr(8'h00, 32'hCCCC);
      chk("run", run, 1);
      repeat (100) @(posedge clk_i);
      rd(8'h18); chk("cnt", rdat, 32'h2);
      p0 = pulses;
      wr(8'h00, 32'hAAAA);
      chk("pulse", pulses, p0);
      wr(8'h00, 32'h5555);
      wr(8'h10, 32'h1);
      settle();
      wr(8'h00, 32'hAAAA);
      chk("pulse", pulses, p0 + 1);
      chk("run", run, 0);
      halt <= 0;
      wr(8'h00, 32'hAAAA);
      p0 = pulses;
      wr(8'h00, 32'hCCCC);
      wait_pulse();
      // random prescaler code, then a short run timed end to end
      v = rnd();
      wr(8'h00, 32'h5555);
      wr(8'h04, {29'h0, v[2:0]});
      settle();
      rd(8'h04); chk("psc", rdat, {29'h0, v[2:0]});
      wr(8'h08, 32'h2);
      settle();
      wr(8'h00, 32'hAAAA);
      p0 = pulses;
      wr(8'h00, 32'hCCCC);
      wait_pulse();
      p = psc_period(v[2:0]);
      chk("period", n >= 2 * p - 2 * OSC - 2 && n <= 2 * p + 4, 1);
      // a second reset in mid-run brings back the run, reload, window and status reset values
      wr(8'h00, 32'hCCCC);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      chk("run", run, 0);
      rd(8'h08); chk("rld", rdat, 32'hFFF);
      rd(8'h10); chk("wnd", rdat, 32'hFFF);
      rd(8'h0C); chk("stat", rdat, 32'h0);
      print_verdict();
   end
endmodule // tb
